// ===== srfd_pkg.sv
package srfd_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_RXPORT = 8'h24;
  localparam logic [7:0] OFF_DESC0 = 8'h30;
  localparam int NUM_DESC = 16;

  // control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_SLOT_LO = 8;

  // status and mask bit positions
  localparam int ST_DONE = 0;
  localparam int ST_RXERR = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // descriptor field positions
  localparam int DESC_LEN_LO = 17;
  localparam int DESC_LAST = 16;
  localparam int DESC_NEXT_LO = 12;
  localparam int DESC_UNIT_LO = 10;
  localparam int DESC_CLOSE = 9;

  // one descriptor slot, packed in register layout
  typedef struct packed {
    logic [14:0] len;
    logic last;
    logic [3:0] next;
    logic [1:0] units;
    logic close;
    logic [8:0] rsvd;
  } srfd_desc_s;

  localparam srfd_desc_s DESC_RESET = 32'h0000_0200;

  // transfer length units
  typedef enum logic [1:0] {
    UNIT_BIT, UNIT_BYTE, UNIT_SEG4, UNIT_SEG16
  } srfd_unit_e;

  // data line modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_QUAD = 2'h2;

  // read access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

  localparam int FIFO_DEPTH = 16;
  localparam int BITS_W = 22;

  typedef logic [BITS_W-1:0] srfd_bits_t;

endpackage : srfd_pkg

// ===== srfd_rx_fifo.sv
`timescale 1ns/1ps
module srfd_rx_fifo (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pushValid,
  input wire logic [7:0] pushData,
  output logic pushReady,
  input wire logic [2:0] popNum,
  output logic [31:0] peek,
  output logic [4:0] count,
  output logic [2:0] popTake
);

  logic [7:0] mem [srfd_pkg::FIFO_DEPTH];
  logic [3:0] rdPtr;
  logic [3:0] wrPtr;
  logic pushGo;

  // back-pressure: engine stalls while full
  assign pushReady = count < 5'(srfd_pkg::FIFO_DEPTH);
  assign pushGo = pushValid && pushReady;
  // an oversized read takes only what is held
  assign popTake = (5'(popNum) > count) ? count[2:0] : popNum;

  // head bytes, low aligned; missing bytes read zero
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      peek[8*i +: 8] = (5'(i) < count) ? mem[rdPtr + 4'(i)] : 8'h00;
    end
  end

  // storage
  always_ff @(posedge mclk) begin
    if (pushGo) begin
      mem[wrPtr] <= pushData;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdPtr <= 4'h0;
      wrPtr <= 4'h0;
      count <= 5'h00;
    end else begin
      wrPtr <= wrPtr + 4'(pushGo);
      rdPtr <= rdPtr + 4'(popTake);
      count <= 5'(count + 5'(pushGo) - 5'(popTake));
    end
  end

  a_fifo_bound: assert property (@(posedge mclk) disable iff (!resetn)
    count <= 5'(srfd_pkg::FIFO_DEPTH))
    else $error("fifo count above depth");

endmodule : srfd_rx_fifo

// ===== srfd_shifter.sv
`timescale 1ns/1ps
module srfd_shifter (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire srfd_pkg::srfd_bits_t totalBits,
  input wire logic [1:0] lineMode,
  input wire logic stop,
  input wire logic [3:0] ioIn,
  input wire logic byteReady,
  output logic sclk,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic done
);

  logic active;
  logic infinite;
  logic [1:0] halfCnt;
  srfd_pkg::srfd_bits_t bitsLeft;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic [2:0] width;
  logic [7:0] next_shift;
  logic [3:0] next_cnt;
  logic stall;
  logic edgeTick;
  logic rising;
  logic lastEdge;

  // bits per clock edge; single line listens on io1
  always_comb begin
    width = 3'd1;
    next_shift = {shiftReg[6:0], ioIn[1]};
    if (lineMode == srfd_pkg::MODE_DUAL) begin
      width = 3'd2;
      next_shift = {shiftReg[5:0], ioIn[1:0]};
    end else if (lineMode == srfd_pkg::MODE_QUAD) begin
      width = 3'd4;
      next_shift = {shiftReg[3:0], ioIn};
    end
    next_cnt = bitCnt + 4'(width);
  end

  // a byte waiting on a full fifo freezes the clock
  assign stall = byteValid && !byteReady;
  assign edgeTick = active && !stall
                    && (halfCnt == 2'(srfd_pkg::SCK_HALF_CYC - 1));
  assign rising = edgeTick && !sclk;
  assign lastEdge = rising && !infinite && (bitsLeft <= 22'(width));

  // serial clock and bit counting
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      active <= 1'b0;
      infinite <= 1'b0;
      halfCnt <= 2'h0;
      sclk <= 1'b0;
      bitsLeft <= '0;
      shiftReg <= 8'h00;
      bitCnt <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        active <= 1'b0;
        sclk <= 1'b0;
      end else if (start) begin
        active <= 1'b1;
        infinite <= (totalBits == '0);
        bitsLeft <= totalBits;
        halfCnt <= 2'h0;
        bitCnt <= 4'h0;
      end else if (active && !stall) begin
        halfCnt <= edgeTick ? 2'h0 : halfCnt + 2'h1;
        if (edgeTick) begin
          sclk <= !sclk;
        end
        if (rising) begin
          shiftReg <= next_shift;
          bitCnt <= (next_cnt == 4'd8) ? 4'h0 : next_cnt;
          bitsLeft <= bitsLeft - 22'(width);
        end
        // ends on length count
        // the last rising edge still goes out to the slave
        if (lastEdge) begin
          active <= 1'b0;
          done <= 1'b1;
        end
      end else if (!active) begin
        // closing high phase lasts one cycle only
        sclk <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      byteValid <= 1'b0;
      byteData <= 8'h00;
    end else if (rising && (next_cnt == 4'd8 || lastEdge)) begin
      byteValid <= 1'b1;
      byteData <= next_shift;
    end else if (byteReady) begin
      byteValid <= 1'b0;
    end
  end

endmodule : srfd_shifter

// ===== srfd_top.sv
`timescale 1ns/1ps
module srfd_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [1:0] regRdSize,
  output logic [31:0] regRdata,
  input wire logic [3:0] ioIn,
  output logic sclk,
  output logic csn,
  output logic dmaDone,
  output logic irq,
  output logic [4:0] rxCount
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} srfd_state_e;

  srfd_state_e state;
  srfd_pkg::srfd_desc_s desc [srfd_pkg::NUM_DESC];
  logic [1:0] status;
  logic [1:0] mask;
  logic [1:0] lineMode;
  logic [3:0] curSlot;
  logic launch;
  logic [3:0] ioMeta;
  logic [3:0] ioSync;
  logic goPulse;
  logic stopPulse;
  logic engStop;
  logic engDone;
  logic byteValid;
  logic [7:0] byteData;
  logic byteReady;
  logic [2:0] popNum;
  logic [2:0] popTake;
  logic [31:0] peek;
  logic portRead;
  logic underflow;
  logic setDone;
  srfd_pkg::srfd_desc_s curDesc;

  // length in bits for the selected units
  function automatic srfd_pkg::srfd_bits_t bitsOf(
    input srfd_pkg::srfd_desc_s d);
    srfd_pkg::srfd_bits_t l;
    l = srfd_pkg::srfd_bits_t'(d.len);
    unique case (srfd_pkg::srfd_unit_e'(d.units))
      srfd_pkg::UNIT_BIT: bitsOf = l;
      srfd_pkg::UNIT_BYTE: bitsOf = l << 3;
      srfd_pkg::UNIT_SEG4: bitsOf = l << 5;
      srfd_pkg::UNIT_SEG16: bitsOf = l << 7;
    endcase
  endfunction : bitsOf

  // bytes a read of the port asks for
  function automatic logic [2:0] sizeBytes(input logic [1:0] sz);
    unique case (sz)
      srfd_pkg::SIZE_BYTE: sizeBytes = 3'd1;
      srfd_pkg::SIZE_WORD: sizeBytes = 3'd2;
      default: sizeBytes = 3'd4;
    endcase
  endfunction : sizeBytes

  // pins come from the slave's timing, so two flops first
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ioMeta <= 4'h0;
      ioSync <= 4'h0;
    end else begin
      ioMeta <= ioIn;
      ioSync <= ioMeta;
    end
  end

  // bus decode
  assign goPulse = regWr && regAddr == srfd_pkg::OFF_CTRL
                   && regWdata[srfd_pkg::CTRL_GO];
  assign stopPulse = regWr && regAddr == srfd_pkg::OFF_CTRL
                     && regWdata[srfd_pkg::CTRL_STOP];
  assign portRead = regRd && regAddr == srfd_pkg::OFF_RXPORT;
  // pop as many bytes as the access size
  assign popNum = portRead ? sizeBytes(regRdSize) : 3'd0;
  assign underflow = portRead && (5'(popNum) > rxCount);
  assign curDesc = desc[curSlot];
  assign engStop = stopPulse && state != ST_IDLE;
  assign setDone = state == ST_RUN && engDone && curDesc.last;

  // sixteen descriptor slots, reserved bits kept zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < srfd_pkg::NUM_DESC; i++) begin
        desc[i] <= srfd_pkg::DESC_RESET;
      end
    end else if (regWr && regAddr >= srfd_pkg::OFF_DESC0
                 && regAddr <= srfd_pkg::OFF_DESC0 + 8'h3C
                 && regAddr[1:0] == 2'b00) begin
      desc[4'(regAddr[5:2] - 4'hC)] <= {regWdata[31:9], 9'h000};
    end
  end

  // control fields that persist
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lineMode <= srfd_pkg::MODE_SINGLE;
      mask <= srfd_pkg::MASK_RESET;
    end else if (regWr) begin
      if (regAddr == srfd_pkg::OFF_CTRL) begin
        lineMode <= regWdata[srfd_pkg::CTRL_MODE_LO +: 2];
      end
      if (regAddr == srfd_pkg::OFF_MASK) begin
        mask <= regWdata[1:0];
      end
    end
  end

  // descriptor sequencing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      curSlot <= 4'h0;
      launch <= 1'b0;
      csn <= 1'b1;
      dmaDone <= 1'b0;
    end else begin
      launch <= 1'b0;
      dmaDone <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (goPulse) begin
            state <= ST_RUN;
            curSlot <= regWdata[srfd_pkg::CTRL_SLOT_LO +: 4];
            launch <= 1'b1;
            csn <= 1'b0;
          end
        end
        ST_RUN: begin
          if (stopPulse) begin
            state <= ST_IDLE;
            csn <= 1'b1;
          end else if (engDone && !curDesc.last) begin
            curSlot <= curDesc.next;
            launch <= 1'b1;
          end else if (engDone && curDesc.close) begin
            // close: cs off, idle, dma done
            state <= ST_IDLE;
            csn <= 1'b1;
            dmaDone <= 1'b1;
          end else if (engDone) begin
            // keep cs low, wait for more
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (stopPulse) begin
            state <= ST_IDLE;
            csn <= 1'b1;
          end else if (goPulse) begin
            state <= ST_RUN;
            curSlot <= regWdata[srfd_pkg::CTRL_SLOT_LO +: 4];
            launch <= 1'b1;
          end
        end
      endcase
    end
  end

  // sticky status; a set in the clearing read wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      status <= srfd_pkg::STATUS_RESET;
    end else begin
      if (regRd && regAddr == srfd_pkg::OFF_STATUS) begin
        status <= 2'b00;
      end
      if (setDone) begin
        status[srfd_pkg::ST_DONE] <= 1'b1;
      end
      if (underflow) begin
        status[srfd_pkg::ST_RXERR] <= 1'b1;
      end
    end
  end

  assign irq = |(status & mask);

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= 32'h0000_0000;
      if (portRead) begin
        regRdata <= peek & ((regRdSize == srfd_pkg::SIZE_BYTE)
          ? 32'h0000_00FF : (regRdSize == srfd_pkg::SIZE_WORD)
          ? 32'h0000_FFFF : 32'hFFFF_FFFF);
      end else if (regAddr == srfd_pkg::OFF_STATUS) begin
        regRdata <= {30'h0000_0000, status};
      end else if (regAddr == srfd_pkg::OFF_MASK) begin
        regRdata <= {30'h0000_0000, mask};
      end else if (regAddr == srfd_pkg::OFF_COUNT) begin
        regRdata <= {27'h000_0000, rxCount};
      end else if (regAddr == srfd_pkg::OFF_CTRL) begin
        regRdata <= {20'h0_0000, curSlot, 2'b00, lineMode,
                     2'b00, state != ST_IDLE ? 2'b01 : 2'b00};
      end else if (regAddr >= srfd_pkg::OFF_DESC0
                   && regAddr <= srfd_pkg::OFF_DESC0 + 8'h3C
                   && regAddr[1:0] == 2'b00) begin
        regRdata <= desc[4'(regAddr[5:2] - 4'hC)];
      end
    end
  end

  srfd_shifter u_shifter (
    .mclk(mclk),
    .resetn(resetn),
    .start(launch),
    .totalBits(bitsOf(curDesc)),
    .lineMode(lineMode),
    .stop(engStop),
    .ioIn(ioSync),
    .byteReady(byteReady),
    .sclk(sclk),
    .byteValid(byteValid),
    .byteData(byteData),
    .done(engDone)
  );

  // fill count falls by bytes popped
  srfd_rx_fifo u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .pushValid(byteValid),
    .pushData(byteData),
    .pushReady(byteReady),
    .popNum(popNum),
    .peek(peek),
    .count(rxCount),
    .popTake(popTake)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_close_cs_off: assert property (
    state == ST_RUN && engDone && curDesc.last && curDesc.close
    && !stopPulse |=> csn && dmaDone && state == ST_IDLE)
    else $error("close did not release chip select");
  a_open_keeps_cs: assert property (
    state == ST_RUN && engDone && curDesc.last && !curDesc.close
    && !stopPulse |=> !csn && !dmaDone && state == ST_HOLD)
    else $error("open end dropped chip select");
  a_chain_no_status: assert property (
    state == ST_RUN && engDone && !curDesc.last && !stopPulse
    |=> launch && !dmaDone && !$rose(status[srfd_pkg::ST_DONE]))
    else $error("chain step misbehaved");
  a_last_sets_done: assert property (
    setDone |=> status[srfd_pkg::ST_DONE])
    else $error("complete status not set");
  a_underflow_err: assert property (
    underflow |=> status[srfd_pkg::ST_RXERR])
    else $error("underflow not flagged");
  a_count_drop: assert property (
    portRead && !byteValid
    |=> rxCount == $past(rxCount) - 5'($past(popTake)))
    else $error("fill count not reduced");
  a_byte_read: assert property (
    portRead && regRdSize == srfd_pkg::SIZE_BYTE
    |=> regRdata[31:8] == 24'h00_0000)
    else $error("byte read upper bits set");
  a_irq_level: assert property (
    setDone && mask[srfd_pkg::ST_DONE] |=> irq)
    else $error("interrupt level wrong");
  a_next_slot: assert property (
    state == ST_RUN && engDone && !curDesc.last && !stopPulse
    |=> curSlot == $past(curDesc.next))
    else $error("successor slot not taken");
  a_infinite_run: assert property (
    launch && bitsOf(curDesc) == '0 |=> !engDone [*8])
    else $error("zero length finished");

  c_close_end: cover property (state == ST_RUN ##[1:1000] dmaDone);
  c_chain: cover property (launch ##[2:1000] launch);
  c_underflow: cover property (underflow);

endmodule : srfd_top

// ===== srfd_slave_model.sv
`timescale 1ns/1ps
// serial slave: answers on io1 msb first, byte k of a frame is 0xc3^k
module srfd_slave_model (
  input wire logic sclk,
  input wire logic csn,
  output logic [3:0] ioOut
);
  int bitIdx;
  logic [7:0] curByte;
  logic curBit;
  logic [3:0] noise;

  // current bit from the frame position
  assign curByte = 8'hC3 ^ 8'(bitIdx / 8);
  assign curBit = curByte[7 - (bitIdx % 8)];
  // the master samples through two flops, so the next bit goes out
  // right after the rising edge that took the last one
  assign ioOut = {noise[3:2], csn ? noise[1] : curBit, noise[0]};

  initial begin
    bitIdx = 0;
    noise = 4'h5;
  end

  // count bits taken by the master; restart when the frame closes
  always @(posedge sclk or posedge csn) begin
    if (csn) begin
      bitIdx <= 0;
    end else begin
      bitIdx <= bitIdx + 1;
    end
  end

  // unused or released lines toggle so a stale value can never pass
  always @(negedge sclk or negedge csn or posedge csn) begin
    noise <= ~noise;
  end
endmodule : srfd_slave_model

// ===== srfd_top_tb.sv
`timescale 1ns/1ps
module srfd_top_tb;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } srfd_row_s;

  // plain accesses: writes, or reads with the value they must return
  localparam srfd_row_s ROWS [8] = '{
    '{1'b0, 8'h30, 32'h0000_0200}, '{1'b0, 8'h34, 32'h0000_0200},
    '{1'b0, 8'h08, 32'h0000_0000}, '{1'b0, 8'h10, 32'h0000_0000},
    '{1'b1, 8'h6C, 32'hFFFF_FFFF}, '{1'b0, 8'h6C, 32'hFFFF_FE00},
    '{1'b1, 8'h14, 32'h1234_5678}, '{1'b0, 8'h14, 32'h0000_0000}};

  logic mclk, resetn, regWr, regRd, sclk, csn, dmaDone, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [1:0] regRdSize;
  logic [3:0] ioIn;
  logic [4:0] rxCount;
  int mismatches, checks_done, rises, dones, csnUps;

  srfd_top dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdSize(regRdSize), .regRdata(regRdata), .ioIn(ioIn),
    .sclk(sclk), .csn(csn), .dmaDone(dmaDone), .irq(irq),
    .rxCount(rxCount));
  srfd_slave_model slave (.sclk(sclk), .csn(csn), .ioOut(ioIn));

  // 50 MHz controller clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // event counters watched by the scenarios
  always @(posedge sclk) rises++;
  always @(posedge csn) csnUps++;
  always @(posedge mclk) if (dmaDone === 1'b1) dones++;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: data %h not %h", $time, got, exp);
    end
  endtask : checkData

  task automatic checkFlag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : checkFlag

  task automatic checkNum(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      mismatches++;
      $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask : checkNum

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wrReg

  // data stand from the cycle after the strobe edge until the next read
  task automatic rdReg(input logic [7:0] a, input logic [1:0] s);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    regRdSize <= s;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask : rdReg

  function automatic logic [31:0] mkDesc(input int len, input logic last,
      input logic [3:0] nxt, input logic [1:0] u, input logic c);
    return {15'(len), last, nxt, u, c, 9'h000};
  endfunction : mkDesc

  function automatic logic [31:0] streamWord(input int k);
    return {8'hC3 ^ 8'(k + 3), 8'hC3 ^ 8'(k + 2), 8'hC3 ^ 8'(k + 1),
      8'hC3 ^ 8'(k)};
  endfunction : streamWord

  // bounded wait for a bit count, then let the close settle
  task automatic goWait(input int n);
    int i;
    rises = 0;
    dones = 0;
    csnUps = 0;
    wrReg(srfd_pkg::OFF_CTRL, 32'h0000_0001);
    for (i = 0; i < 4000 && rises < n; i++) @(posedge mclk);
    repeat (8) @(posedge mclk);
  endtask : goWait

  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  initial begin
    int i;
    {regWr, regRd, regAddr, regWdata, regRdSize} = '0;
    {mismatches, checks_done, rises, dones, csnUps} = '0;
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    #1 checkFlag(csn, 1'b1);
    checkFlag(irq, 1'b0);
    checkData(32'(rxCount), 0);
    foreach (ROWS[j]) begin
      if (ROWS[j].wr) begin
        wrReg(ROWS[j].addr, ROWS[j].data);
      end else begin
        rdReg(ROWS[j].addr, srfd_pkg::SIZE_DWORD);
        checkData(rd, ROWS[j].data);
      end
    end
    // two bytes, last and close, complete unmasked
    wrReg(srfd_pkg::OFF_MASK, 32'h0000_0001);
    wrReg(srfd_pkg::OFF_DESC0, mkDesc(2, 1, 0, 1, 1));
    goWait(16);
    checkNum(rises, 16);
    checkNum(dones, 1);
    checkFlag(csn, 1'b1);
    checkFlag(irq, 1'b1);
    checkData(32'(rxCount), 2);
    rdReg(srfd_pkg::OFF_RXPORT, srfd_pkg::SIZE_BYTE);
    checkData(rd, 32'h0000_00C3);
    checkData(32'(rxCount), 1);
    // word read with one byte held underflows
    rdReg(srfd_pkg::OFF_RXPORT, srfd_pkg::SIZE_WORD);
    checkData(rd, 32'h0000_00C2);
    checkData(32'(rxCount), 0);
    rdReg(srfd_pkg::OFF_STATUS, srfd_pkg::SIZE_DWORD);
    checkData(rd, 32'h0000_0003);
    rdReg(srfd_pkg::OFF_STATUS, srfd_pkg::SIZE_DWORD);
    checkData(rd, 32'h0000_0000);
    checkFlag(irq, 1'b0);
    // chain slot 0 (8 bits) to slot 5 (one 4-byte unit), masked
    wrReg(srfd_pkg::OFF_MASK, 32'h0000_0000);
    wrReg(srfd_pkg::OFF_DESC0, mkDesc(8, 0, 5, 0, 0));
    wrReg(8'h44, mkDesc(1, 1, 0, 2, 1));
    goWait(40);
    checkNum(rises, 40);
    checkNum(csnUps, 1);
    checkNum(dones, 1);
    checkFlag(irq, 1'b0);
    checkData(32'(rxCount), 5);
    rdReg(srfd_pkg::OFF_STATUS, srfd_pkg::SIZE_DWORD);
    checkData(rd, 32'h0000_0001);
    rdReg(srfd_pkg::OFF_RXPORT, srfd_pkg::SIZE_DWORD);
    checkData(rd, streamWord(0));
    rdReg(srfd_pkg::OFF_RXPORT, srfd_pkg::SIZE_BYTE);
    checkData(rd, 32'h0000_00C7);
    checkData(32'(rxCount), 0);
    // last without close holds the frame open until stop
    wrReg(srfd_pkg::OFF_DESC0, mkDesc(1, 1, 0, 1, 0));
    goWait(8);
    checkFlag(csn, 1'b0);
    checkNum(dones, 0);
    wrReg(srfd_pkg::OFF_CTRL, 32'h0000_0002);
    repeat (4) @(posedge mclk);
    checkFlag(csn, 1'b1);
    rdReg(srfd_pkg::OFF_RXPORT, srfd_pkg::SIZE_BYTE);
    checkData(rd, 32'h0000_00C3);
    // zero length never ends; a full fifo stalls the clock
    wrReg(srfd_pkg::OFF_DESC0, mkDesc(0, 1, 0, 1, 1));
    goWait(0);
    for (i = 0; i < 1000 && rxCount !== 5'h10; i++) @(posedge mclk);
    repeat (40) @(posedge mclk);
    checkData(32'(rxCount), 16);
    checkFlag(csn, 1'b0);
    checkNum(dones, 0);
    for (i = 0; i < 4; i++) begin
      rdReg(srfd_pkg::OFF_RXPORT, srfd_pkg::SIZE_DWORD);
      checkData(rd, streamWord(4 * i));
    end
    repeat (700) @(posedge mclk);
    rdReg(srfd_pkg::OFF_COUNT, srfd_pkg::SIZE_DWORD);
    checkData(rd, 32'h0000_0010);
    checkFlag(csn, 1'b0);
    // reset in mid-run drops the frame and empties the fifo
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    #1 checkFlag(csn, 1'b1);
    checkData(32'(rxCount), 0);
    finish_test();
  end
endmodule : srfd_top_tb
